/* File: channel_power_slot_enable_regs.v */
// Register bank for output slot enables, power configuration and channel power status.
`timescale 1ns/1ps
`include "channel_power_defs.vh"
module channel_power_slot_enable_regs (
  input  wire                    ref_clk_in,
  input  wire                    rst_in,
  input  wire                    clk_en_in,
  input  wire                    reg_write_in,
  input  wire                    reg_read_in,
  input  wire [`REG_ADDR_W-1:0]  reg_addr_in,
  input  wire [`REG_DATA_W-1:0]  reg_wdata_in,
  output reg  [`REG_DATA_W-1:0]  reg_rdata_out,
  output wire [`REG_DATA_W-1:0]  slot_drive_en_out,
  output wire                    bias_power_on_out,
  output wire                    synth_power_on_out,
  output wire [`REG_DATA_W-1:0]  decimation_power_out
);
  reg  [`REG_DATA_W-1:0] input_channel_enable;
  reg  [`REG_DATA_W-1:0] output_slot_enable;
  reg  [`REG_DATA_W-1:0] power_configuration;
  reg  [`REG_DATA_W-1:0] limit_mask;
  reg  [`REG_DATA_W-1:0] next_rdata;
  wire [`REG_DATA_W-1:0] channel_power_status;
  wire [`REG_DATA_W-1:0] want_on;
  wire                   decimation_power_on;
  wire                   per_channel_dynamic_power;
  wire [1:0]             dynamic_channel_limit;

  assign decimation_power_on       = power_configuration[`BIT_DECIM_ON];
  assign per_channel_dynamic_power = power_configuration[`BIT_DYNAMIC];
  assign dynamic_channel_limit     = power_configuration[`LIMIT_HI:`LIMIT_LO];

  always @* begin
    case (dynamic_channel_limit)
      `LIMIT_CH2: limit_mask = `MASK_CH2;
      `LIMIT_CH4: limit_mask = `MASK_CH4;
      `LIMIT_CH6: limit_mask = `MASK_CH6;
      `LIMIT_CH8: limit_mask = `MASK_CH8;
      default:    limit_mask = `MASK_CH8;
    endcase
  end

  // Channels beyond the dynamic limit stay off while dynamic mode is in use.
  assign want_on = (decimation_power_on ? input_channel_enable : `ZERO_BYTE)
                 & (per_channel_dynamic_power ? limit_mask : `MASK_CH8);

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      input_channel_enable <= `RST_INPUT_ENABLE;
      output_slot_enable   <= `RST_SLOT_ENABLE;
      power_configuration  <= `RST_POWER_CONFIG;
    end else if (clk_en_in && reg_write_in) begin
      case (reg_addr_in)
        `ADDR_INPUT_ENABLE: input_channel_enable <= reg_wdata_in;
        `ADDR_SLOT_ENABLE:  output_slot_enable   <= reg_wdata_in;
        `ADDR_POWER_CONFIG: power_configuration  <= reg_wdata_in & `POWER_CONFIG_WMASK;
        default: begin
        end
      endcase
    end
  end

  channel_power_tracker u_tracker (
    .ref_clk_in      (ref_clk_in),
    .rst_in          (rst_in),
    .clk_en_in       (clk_en_in),
    .want_on_in      (want_on),
    .allow_change_in (per_channel_dynamic_power),
    .powered_out     (channel_power_status)
  );

  always @* begin
    case (reg_addr_in)
      `ADDR_INPUT_ENABLE: next_rdata = input_channel_enable;
      `ADDR_SLOT_ENABLE:  next_rdata = output_slot_enable;
      `ADDR_POWER_CONFIG: next_rdata = power_configuration;
      `ADDR_POWER_STATUS: next_rdata = channel_power_status;
      default:            next_rdata = `ZERO_BYTE;
    endcase
  end

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= `RST_POWER_STATUS;
    end else if (clk_en_in && reg_read_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  // Slot enables only gate the serial driver; the pad itself lives outside.
  assign slot_drive_en_out    = output_slot_enable;
  assign bias_power_on_out    = power_configuration[`BIT_BIAS_ON];
  assign synth_power_on_out   = power_configuration[`BIT_SYNTH_ON];
  assign decimation_power_out = channel_power_status;
endmodule // channel_power_slot_enable_regs

/* File: channel_power_defs.vh */
// Register map, field positions and reset values of the channel power register bank.
`ifndef CHANNEL_POWER_DEFS_VH
`define CHANNEL_POWER_DEFS_VH
`define REG_ADDR_W          7
`define REG_DATA_W          8
`define CHANNEL_COUNT       8
`define ADDR_INPUT_ENABLE   7'h73
`define ADDR_SLOT_ENABLE    7'h74
`define ADDR_POWER_CONFIG   7'h75
`define ADDR_POWER_STATUS   7'h76
`define RST_INPUT_ENABLE    8'hf0
`define RST_SLOT_ENABLE     8'h00
`define RST_POWER_CONFIG    8'h00
`define RST_POWER_STATUS    8'h00
`define BIT_BIAS_ON         7
`define BIT_DECIM_ON        6
`define BIT_SYNTH_ON        5
`define BIT_DYNAMIC         4
`define LIMIT_HI            3
`define LIMIT_LO            2
`define BIT_SPARE_RW        1
`define POWER_CONFIG_WMASK  8'hfe
`define LIMIT_CH2           2'h0
`define LIMIT_CH4           2'h1
`define LIMIT_CH6           2'h2
`define LIMIT_CH8           2'h3
`define MASK_CH2            8'hc0
`define MASK_CH4            8'hf0
`define MASK_CH6            8'hfc
`define MASK_CH8            8'hff
`define ZERO_BYTE           8'h00
`endif

/* File: channel_power_tracker.v */
// Per-channel power state tracker feeding the power status register.
`timescale 1ns/1ps
`include "channel_power_defs.vh"
module channel_power_tracker (
  input  wire                      ref_clk_in,
  input  wire                      rst_in,
  input  wire                      clk_en_in,
  input  wire [`REG_DATA_W-1:0]    want_on_in,
  input  wire                      allow_change_in,
  output wire [`REG_DATA_W-1:0]    powered_out
);
  reg  [`REG_DATA_W-1:0] powered;
  wire [`REG_DATA_W-1:0] next_powered;
  wire                   any_on;
  assign any_on = |powered;
  genvar i;
  generate
    for (i = 0; i < `CHANNEL_COUNT; i = i + 1) begin : g_ch
      // Without dynamic mode a channel may only rise while all channels are idle,
      // except that powering down is always honoured so the device can be shut off.
      assign next_powered[i] = want_on_in[i] & (allow_change_in | ~any_on | powered[i]);
    end
  endgenerate
  // One register for all channels keeps a single driver on the status word.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      powered <= `ZERO_BYTE;
    end else if (clk_en_in) begin
      powered <= next_powered;
    end
  end
  assign powered_out = powered;
endmodule // channel_power_tracker

/* File: channel_power_slot_enable_regs_properties.sv */
// Port-level checks of the channel power register bank.
`timescale 1ns/1ps
module power_regs_checker (
  input wire       ref_clk_in,
  input wire       rst_in,
  input wire       clk_en_in,
  input wire       reg_write_in,
  input wire       reg_read_in,
  input wire [6:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire [7:0] reg_rdata_out,
  input wire [7:0] slot_drive_en_out,
  input wire       bias_power_on_out,
  input wire       synth_power_on_out,
  input wire [7:0] decimation_power_out
);
  wire wr = clk_en_in && reg_write_in;
  wire cfg = wr && reg_addr_in == 7'h75;
  wire rd = clk_en_in && reg_read_in;
  reg  dyn_on;
  // Mirrors the dynamic bit so the ordering check needs no look inside the design.
  always @(posedge ref_clk_in or posedge rst_in)
    if (rst_in) dyn_on <= 1'b0;
    else if (cfg) dyn_on <= reg_wdata_in[4];
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  chk_slot_write: assert property (wr && reg_addr_in == 7'h74 |=>
    slot_drive_en_out == $past(reg_wdata_in)) else $error("slot enable not taken");
  chk_slot_hold: assert property (
    !(wr && reg_addr_in == 7'h74) |=> $stable(slot_drive_en_out)) else $error("slot moved");
  chk_power_write: assert property (cfg |=> bias_power_on_out == $past(reg_wdata_in[7]) &&
    synth_power_on_out == $past(reg_wdata_in[5])) else $error("power bits not taken");
  chk_power_hold: assert property (
    !cfg |=> $stable({bias_power_on_out, synth_power_on_out})) else $error("power bit moved");
  chk_reset_zero: assert property ($fell(rst_in) |-> !bias_power_on_out &&
    !synth_power_on_out &&
    {reg_rdata_out, slot_drive_en_out, decimation_power_out} == 24'h0)
    else $error("not reset");
  chk_status_read: assert property (rd && reg_addr_in == 7'h76 |=>
    reg_rdata_out == $past(decimation_power_out)) else $error("status read wrong");
  chk_read_hold: assert property (
    !rd |=> $stable(reg_rdata_out)) else $error("read data moved");
  chk_decim_off: assert property (cfg && !reg_wdata_in[6] ##1 clk_en_in |=>
    decimation_power_out == 8'h00) else $error("channels stayed powered");
  chk_no_dyn_up: assert property (!dyn_on && |decimation_power_out |=>
    (decimation_power_out & ~$past(decimation_power_out)) == 8'h00) else $error("channel rose");
  cover property (cfg && reg_wdata_in[4]);
  cover property (rd && reg_addr_in == 7'h76 ##1 reg_rdata_out != 8'h00);
  cover property (!dyn_on && |decimation_power_out);
endmodule // power_regs_checker
bind channel_power_slot_enable_regs power_regs_checker chk (.*);

/* File: tb.sv */
// Self-checking bench for the channel power register bank.
`timescale 1ns/1ps
module tb;
  reg         clk = 0, rst = 1, en = 1, we = 0, re = 0;
  reg  [6:0]  addr = 7'h00;
  reg  [7:0]  wd = 8'h00;
  reg  [31:0] masks = 32'hc0f0fcff;
  wire [7:0]  rdata, slot, decim;
  wire        bias, synth;
  integer     n_fail = 0, cmp_count = 0, i;
  channel_power_slot_enable_regs uut (.ref_clk_in(clk), .rst_in(rst), .clk_en_in(en),
    .reg_write_in(we), .reg_read_in(re), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_rdata_out(rdata), .slot_drive_en_out(slot), .bias_power_on_out(bias),
    .synth_power_on_out(synth), .decimation_power_out(decim));
  initial forever #10 clk = ~clk;
  task cmp(input [63:0] what, input [7:0] exp, input [7:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Each access starts one falling edge after the last one ended, so a strobe is never
  // lowered and raised again in the same time step.
  task put(input [6:0] a, input [7:0] d);
    begin
      @(negedge clk);
      addr = a;
      wd = d;
      we = 1;
      @(negedge clk);
      we = 0;
    end
  endtask
  task get(input [6:0] a, input [7:0] exp);
    begin
      @(negedge clk);
      addr = a;
      re = 1;
      @(negedge clk);
      re = 0;
      cmp("rdata", exp, rdata);
    end
  endtask
  task test_done;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    cmp("slot", 8'h00, slot);
    cmp("power", 8'h00, {6'h0, bias, synth});
    cmp("decim", 8'h00, decim);
    get(7'h73, 8'hf0);
    get(7'h74, 8'h00);
    get(7'h75, 8'h00);
    get(7'h76, 8'h00);
    put(7'h74, 8'hc1);
    cmp("slot", 8'hc1, slot);
    get(7'h74, 8'hc1);
    en = 0;
    put(7'h74, 8'h00);
    en = 1;
    cmp("slot", 8'hc1, slot);
    put(7'h75, 8'hff);
    cmp("power", 8'h03, {6'h0, bias, synth});
    get(7'h75, 8'hfe);
    cmp("decim", 8'hf0, decim);
    put(7'h73, 8'hff);
    for (i = 0; i < 4; i = i + 1) begin
      put(7'h75, {4'h5, i[1:0], 2'h0});
      @(negedge clk);
      cmp("decim", masks[31-8*i -: 8], decim);
    end
    put(7'h75, 8'h40);
    put(7'h73, 8'h0f);
    @(negedge clk);
    cmp("decim", 8'h0f, decim);
    get(7'h76, 8'h0f);
    put(7'h73, 8'hff);
    repeat (2) @(negedge clk);
    cmp("decim", 8'h0f, decim);
    put(7'h73, 8'h00);
    @(negedge clk);
    cmp("decim", 8'h00, decim);
    put(7'h73, 8'h3c);
    @(negedge clk);
    put(7'h76, 8'hff);
    get(7'h76, 8'h3c);
    put(7'h75, 8'h00);
    @(negedge clk);
    cmp("decim", 8'h00, decim);
    cmp("power", 8'h00, {6'h0, bias, synth});
    get(7'h76, 8'h00);
    get(7'h73, 8'h3c);
    get(7'h10, 8'h00);
    test_done;
  end
endmodule // tb
